// >>> mar_consts.svh
// Purpose: constants for the interrupt-message and error-reporting registers
// Assumes: 32-bit AHB-Lite word access, byte offsets as printed
// Notes: sticky fields clear on power-on reset only
`ifndef MAR_CONSTS_SVH
`define MAR_CONSTS_SVH
`define MAR_OFF_MSI_CTRL 12'h0f0
`define MAR_OFF_MSI_ADDR_LO 12'h0f4
`define MAR_OFF_MSI_ADDR_HI 12'h0f8
`define MAR_OFF_MSI_DATA 12'h0fc
`define MAR_OFF_AER_HDR 12'h100
`define MAR_OFF_UNC_STATUS 12'h104
`define MAR_OFF_UNC_MASK 12'h108
`define MAR_OFF_UNC_SEV 12'h10c
`define MAR_OFF_IRQ_STATUS 12'h140
`define MAR_OFF_IRQ_MASK 12'h144
`define MAR_MSI_CAP_ID 8'h05
`define MAR_MSI_NEXT_PTR 8'h00
`define MAR_MSI_VEC_REQ 3'h0
`define MAR_MSI_ALLOC_RST 3'h0
`define MAR_MSI_ALLOC_MAX 3'h5
`define MAR_MSI_WIDE_RST 1'b1
`define MAR_MSI_EN_BIT 16
`define MAR_MSI_ALLOC_LSB 20
`define MAR_MSI_WIDE_BIT 23
`define MAR_AER_CAP_ID 16'h0001
`define MAR_AER_VERSION 4'h1
`define MAR_AER_NEXT 12'h150
`define MAR_UNC_IMPL 32'h001f_f011
`define MAR_UNC_SEV_RST 32'h0006_2011
`define MAR_IRQ_W 3
`define MAR_IRQ_FATAL 0
`define MAR_IRQ_NONFATAL 1
`define MAR_IRQ_MASKED 2
`define MAR_HSIZE_WORD 3'h2
`endif

// >>> mar_pkg.sv
// Purpose: shared types for the interrupt-message and error-reporting registers
// Assumes: used with mar_consts.svh
// Notes: none
package mar_pkg;
	typedef enum logic {
		MAR_BUS_IDLE = 1'b0,
		MAR_BUS_DATA = 1'b1
	} mar_bus_state_type;
	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic word;
	} mar_access_type;
	typedef struct packed {
		logic fatal;
		logic nonfatal;
		logic msi_write;
	} mar_report_type;
endpackage

// >>> mar_regs.sv
// Purpose: interrupt-message and error-reporting register bank on AHB-Lite
// Assumes: error events are one-cycle pulses on hclk; intx pins are asynchronous
// Notes: every transfer takes one wait state
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "mar_consts.svh"
module mar_regs (
	// bus clock and power-on reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// hot or warm reset, one-cycle pulse on hclk
	input wire logic hot_rst,
	// error events and legacy pin
	input wire logic [31:0] unc_event,
	input wire logic intx_pin,
	// interrupt delivery and reports
	output logic intx_out,
	output logic msi_enable,
	output logic [63:0] msi_addr,
	output logic [15:0] msi_data,
	output var mar_pkg::mar_report_type report,
	output logic irq
);
	import mar_pkg::*;

	mar_bus_state_type state_r;
	mar_access_type acc_r;
	logic done_r;
	logic [31:0] rd_nxt;
	logic wr_en;
	logic msi_en_r;
	logic [2:0] msi_alloc_r;
	logic msi_wide_r;
	logic [29:0] addr_lo_r;
	logic [31:0] addr_hi_r;
	logic [15:0] data_r;
	logic [31:0] unc_status_r;
	logic [31:0] unc_mask_r;
	logic [31:0] unc_sev_r;
	logic [31:0] unc_new;
	logic [`MAR_IRQ_W-1:0] irq_status_r;
	logic [`MAR_IRQ_W-1:0] irq_mask_r;
	logic [`MAR_IRQ_W-1:0] irq_set;
	logic intx_meta_r;
	logic intx_sync_r;
	logic intx_prev_r;
	logic rpt_fatal;
	logic rpt_nonfatal;

	// bus transfer sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= MAR_BUS_IDLE;
			acc_r <= '0;
			hreadyout <= 1'b1;
			done_r <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			unique case (state_r)
				MAR_BUS_IDLE: begin
					done_r <= 1'b0;
					if (hsel && htrans[1] && hready) begin
						acc_r.addr <= haddr[11:0];
						acc_r.write <= hwrite;
						acc_r.word <= (hsize == `MAR_HSIZE_WORD);
						hreadyout <= 1'b0;
						state_r <= MAR_BUS_DATA;
					end
				end
				MAR_BUS_DATA: begin
					hreadyout <= 1'b1;
					done_r <= 1'b1;
					state_r <= MAR_BUS_IDLE;
					if (!acc_r.write) begin
						hrdata <= rd_nxt;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	assign wr_en = (state_r == MAR_BUS_DATA) && acc_r.write && acc_r.word;

	// read multiplexer, unmapped reads zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (acc_r.addr)
			`MAR_OFF_MSI_CTRL: rd_nxt = {8'h00, msi_wide_r, msi_alloc_r, `MAR_MSI_VEC_REQ,
				msi_en_r, `MAR_MSI_NEXT_PTR, `MAR_MSI_CAP_ID};
			`MAR_OFF_MSI_ADDR_LO: rd_nxt = {addr_lo_r, 2'b00};
			`MAR_OFF_MSI_ADDR_HI: rd_nxt = addr_hi_r;
			`MAR_OFF_MSI_DATA: rd_nxt = {16'h0000, data_r};
			`MAR_OFF_AER_HDR: rd_nxt = {`MAR_AER_NEXT, `MAR_AER_VERSION, `MAR_AER_CAP_ID};
			`MAR_OFF_UNC_STATUS: rd_nxt = unc_status_r;
			`MAR_OFF_UNC_MASK: rd_nxt = unc_mask_r;
			`MAR_OFF_UNC_SEV: rd_nxt = unc_sev_r;
			`MAR_OFF_IRQ_STATUS: rd_nxt = {{(32-`MAR_IRQ_W){1'b0}}, irq_status_r};
			`MAR_OFF_IRQ_MASK: rd_nxt = {{(32-`MAR_IRQ_W){1'b0}}, irq_mask_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// message control field, enable and allocation cleared and wide bit set by either reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msi_en_r <= 1'b0;
			msi_alloc_r <= `MAR_MSI_ALLOC_RST;
			msi_wide_r <= `MAR_MSI_WIDE_RST;
		end else if (hot_rst) begin
			msi_en_r <= 1'b0;
			msi_alloc_r <= `MAR_MSI_ALLOC_RST;
			msi_wide_r <= `MAR_MSI_WIDE_RST;
		end else if (wr_en && acc_r.addr == `MAR_OFF_MSI_CTRL) begin
			msi_en_r <= hwdata[`MAR_MSI_EN_BIT];
			msi_wide_r <= hwdata[`MAR_MSI_WIDE_BIT];
			if (hwdata[`MAR_MSI_ALLOC_LSB+2:`MAR_MSI_ALLOC_LSB] <= `MAR_MSI_ALLOC_MAX) begin
				msi_alloc_r <= hwdata[`MAR_MSI_ALLOC_LSB+2:`MAR_MSI_ALLOC_LSB];
			end
		end
	end

	// message address and payload
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_lo_r <= 30'h0;
			addr_hi_r <= 32'h0000_0000;
			data_r <= 16'h0000;
		end else if (hot_rst) begin
			addr_lo_r <= 30'h0;
			addr_hi_r <= 32'h0000_0000;
			data_r <= 16'h0000;
		end else if (wr_en) begin
			if (acc_r.addr == `MAR_OFF_MSI_ADDR_LO) begin
				addr_lo_r <= hwdata[31:2];
			end
			if (acc_r.addr == `MAR_OFF_MSI_ADDR_HI) begin
				addr_hi_r <= hwdata;
			end
			if (acc_r.addr == `MAR_OFF_MSI_DATA) begin
				data_r <= hwdata[15:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unc_status_r <= 32'h0000_0000;
		end else begin
			if (wr_en && acc_r.addr == `MAR_OFF_UNC_STATUS) begin
				unc_status_r <= ((unc_status_r & ~hwdata) | unc_event) & `MAR_UNC_IMPL;
			end else begin
				unc_status_r <= (unc_status_r | unc_event) & `MAR_UNC_IMPL;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unc_mask_r <= 32'h0000_0000;
			unc_sev_r <= `MAR_UNC_SEV_RST;
		end else if (wr_en) begin
			if (acc_r.addr == `MAR_OFF_UNC_MASK) begin
				unc_mask_r <= hwdata & `MAR_UNC_IMPL;
			end
			if (acc_r.addr == `MAR_OFF_UNC_SEV) begin
				unc_sev_r <= hwdata & `MAR_UNC_IMPL;
			end
		end
	end

	assign unc_new = unc_event & ~unc_status_r & `MAR_UNC_IMPL;
	assign rpt_fatal = |(unc_new & ~unc_mask_r & unc_sev_r);
	assign rpt_nonfatal = |(unc_new & ~unc_mask_r & ~unc_sev_r);

	always_comb begin
		irq_set = '0;
		irq_set[`MAR_IRQ_FATAL] = rpt_fatal;
		irq_set[`MAR_IRQ_NONFATAL] = rpt_nonfatal;
		irq_set[`MAR_IRQ_MASKED] = |(unc_new & unc_mask_r);
	end

	// interrupt status, write one clears, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_r <= '0;
			irq_mask_r <= '0;
		end else if (hot_rst) begin
			irq_status_r <= irq_set;
			irq_mask_r <= '0;
		end else begin
			if (wr_en && acc_r.addr == `MAR_OFF_IRQ_STATUS) begin
				irq_status_r <= (irq_status_r & ~hwdata[`MAR_IRQ_W-1:0]) | irq_set;
			end else begin
				irq_status_r <= irq_status_r | irq_set;
			end
			if (wr_en && acc_r.addr == `MAR_OFF_IRQ_MASK) begin
				irq_mask_r <= hwdata[`MAR_IRQ_W-1:0];
			end
		end
	end

	// legacy pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intx_meta_r <= 1'b0;
			intx_sync_r <= 1'b0;
			intx_prev_r <= 1'b0;
		end else begin
			intx_meta_r <= intx_pin;
			intx_sync_r <= intx_meta_r;
			intx_prev_r <= intx_sync_r;
		end
	end

	// interrupt delivery and report outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intx_out <= 1'b0;
			report <= '0;
			irq <= 1'b0;
		end else begin
			intx_out <= intx_sync_r && !msi_en_r;
			report.msi_write <= msi_en_r && intx_sync_r && !intx_prev_r;
			report.fatal <= rpt_fatal;
			report.nonfatal <= rpt_nonfatal;
			irq <= |(irq_status_r & ~irq_mask_r);
		end
	end

	assign msi_enable = msi_en_r;
	assign msi_addr = {addr_hi_r, addr_lo_r, 2'b00};
	assign msi_data = data_r;

	// read checks at the completing data phase, then delivery, error flag and hot reset checks
	chk_msi_header: assert property (@(posedge hclk) disable iff (!hresetn)
		(done_r && !acc_r.write && acc_r.addr == `MAR_OFF_MSI_CTRL)
		|-> (hrdata[7:0] == 8'h05 && hrdata[15:8] == 8'h00))
		else $error("message header bytes wrong");

	chk_vec_request: assert property (@(posedge hclk) disable iff (!hresetn)
		(done_r && !acc_r.write && acc_r.addr == `MAR_OFF_MSI_CTRL)
		|-> (hrdata[19:17] == 3'h0 && hrdata[31:24] == 8'h00))
		else $error("vector request field wrong");

	chk_addr_align: assert property (@(posedge hclk) disable iff (!hresetn)
		(done_r && !acc_r.write && acc_r.addr == `MAR_OFF_MSI_ADDR_LO)
		|-> (hrdata[1:0] == 2'b00))
		else $error("low address bits not zero");

	chk_aer_header: assert property (@(posedge hclk) disable iff (!hresetn)
		(done_r && !acc_r.write && acc_r.addr == `MAR_OFF_AER_HDR)
		|-> (hrdata == 32'h1501_0001))
		else $error("error header value wrong");

	chk_legacy_path: assert property (@(posedge hclk) disable iff (!hresetn)
		(!msi_en_r && intx_sync_r) |=> intx_out)
		else $error("legacy interrupt not passed");

	chk_pins_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
		msi_en_r |=> !intx_out)
		else $error("legacy pin seen while messages enabled");

	chk_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(unc_event & `MAR_UNC_IMPL))
		|=> ((unc_status_r & $past(unc_event & `MAR_UNC_IMPL)) == $past(unc_event & `MAR_UNC_IMPL)))
		else $error("error event lost");

	chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		((unc_mask_r | unc_sev_r | unc_status_r) & ~`MAR_UNC_IMPL) == 32'h0000_0000)
		else $error("reserved error bit set");

	chk_fatal_report: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(unc_event & ~unc_status_r & ~unc_mask_r & unc_sev_r & `MAR_UNC_IMPL))
		|=> (report.fatal && irq_status_r[`MAR_IRQ_FATAL]))
		else $error("fatal report missing");

	chk_sticky_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(hot_rst && !wr_en && unc_event == 32'h0000_0000)
		|=> (unc_status_r == $past(unc_status_r) && unc_sev_r == $past(unc_sev_r)))
		else $error("sticky bits lost on hot reset");

	// report class, clearing, reset, field write and payload read checks
	chk_nonfatal_report: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(unc_event & ~unc_status_r & ~unc_mask_r & ~unc_sev_r & `MAR_UNC_IMPL))
		|=> (report.nonfatal && irq_status_r[`MAR_IRQ_NONFATAL]))
		else $error("non-fatal report missing");

	chk_masked_silent: assert property (@(posedge hclk) disable iff (!hresetn)
		((|(unc_event & ~unc_status_r & `MAR_UNC_IMPL))
		&& !(|(unc_event & ~unc_status_r & ~unc_mask_r & `MAR_UNC_IMPL)))
		|=> (!report.fatal && !report.nonfatal && irq_status_r[`MAR_IRQ_MASKED]))
		else $error("masked error reported");

	chk_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && acc_r.addr == `MAR_OFF_UNC_STATUS && unc_event == 32'h0000_0000)
		|=> ((unc_status_r & $past(hwdata)) == 32'h0000_0000))
		else $error("error flag not cleared");

	chk_alloc_legal: assert property (@(posedge hclk) disable iff (!hresetn)
		msi_alloc_r <= `MAR_MSI_ALLOC_MAX)
		else $error("reserved allocation code held");

	chk_hot_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		hot_rst |=> (!msi_en_r && msi_alloc_r == `MAR_MSI_ALLOC_RST
		&& msi_wide_r == `MAR_MSI_WIDE_RST && addr_lo_r == 30'h0
		&& addr_hi_r == 32'h0000_0000 && data_r == 16'h0000))
		else $error("message fields kept over hot reset");

	chk_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && acc_r.addr == `MAR_OFF_UNC_MASK)
		|=> (unc_mask_r == ($past(hwdata) & `MAR_UNC_IMPL)))
		else $error("mask write wrong");

	chk_payload_upper: assert property (@(posedge hclk) disable iff (!hresetn)
		(done_r && !acc_r.write && acc_r.addr == `MAR_OFF_MSI_DATA)
		|-> (hrdata[31:16] == 16'h0000))
		else $error("payload upper half not zero");
endmodule
`default_nettype wire

// >>> mar_host.sv
// Purpose: ahb-lite master standing in for configuration software
// Assumes: one slave, single transfers of the size given by the caller
// Notes: xfer is entered right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module mar_host (
	// clock and bus return
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// bus request
	output var logic hsel,
	output var logic [31:0] haddr,
	output var logic [1:0] htrans,
	output var logic hwrite,
	output var logic [2:0] hsize,
	output var logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// address phase held until accepted, then data phase until ready
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [2:0] s, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= s;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
endmodule
`default_nettype wire

// >>> msi_aer_capability_regs_tb_top.sv
// Purpose: self-checking bench for the message and error register bank
// Assumes: one wait state per transfer, events are one-cycle pulses
// Notes: sticky fields checked across hot and power-on reset
`timescale 1ns/10ps
`default_nettype none
module msi_aer_capability_regs_tb_top;
	import mar_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hot_rst = 1'b0;
	logic intx_pin = 1'b0;
	logic [31:0] unc_event = 32'h0;
	logic hsel, hwrite, hreadyout, hresp, intx_out, msi_enable, irq, f, n, m;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [63:0] msi_addr;
	logic [15:0] msi_data;
	mar_report_type report;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2.5 hclk = ~hclk;
	mar_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.hot_rst(hot_rst), .unc_event(unc_event), .intx_pin(intx_pin),
		.intx_out(intx_out), .msi_enable(msi_enable), .msi_addr(msi_addr),
		.msi_data(msi_data), .report(report), .irq(irq));
	mar_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			tally_and_finish();
		end
	end
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task automatic hold(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, 3'h2, q);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h0, 3'h2, q);
		chk32(q, e);
	endtask
	task automatic do_reset();
		hresetn <= 1'b0;
		hold(2);
		hresetn <= 1'b1;
		hold(1);
	endtask
	task automatic pulse(input int i);
		unc_event <= 32'h1 << i;
		@(posedge hclk);
		unc_event <= 32'h0;
		f = 1'b0;
		n = 1'b0;
		repeat (3) begin
			@(posedge hclk);
			f = f | report.fatal;
			n = n | report.nonfatal;
		end
	endtask
	task automatic t_reset();
		logic [31:0] a[11] = '{32'hf0, 32'hf4, 32'hf8, 32'hfc, 32'h100, 32'h104,
			32'h108, 32'h10c, 32'h140, 32'h144, 32'h200};
		logic [31:0] e[11] = '{32'h0080_0005, 0, 0, 0, 32'h1501_0001, 0, 0,
			32'h0006_2011, 0, 0, 0};
		for (int i = 0; i < 11; i++) rd(a[i], e[i]);
		chk1(intx_out, 1'b0);
		$display("test reset values done");
	endtask
	task automatic t_rw();
		logic [31:0] a[9] = '{32'hf0, 32'hf0, 32'hf4, 32'hf8, 32'hfc, 32'h100,
			32'h108, 32'h10c, 32'h104};
		logic [31:0] w[9] = '{32'hffff_ffff, 32'h0050_0000, 32'hffff_ffff, 32'hffff_ffff,
			32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h0, 32'hffff_ffff};
		logic [31:0] e[9] = '{32'h0081_0005, 32'h0050_0005, 32'hffff_fffc, 32'hffff_ffff,
			32'h0000_ffff, 32'h1501_0001, 32'h001f_f011, 32'h0, 32'h0};
		for (int i = 0; i < 9; i++) begin
			wr(a[i], w[i]);
			rd(a[i], e[i]);
		end
		chk32(msi_addr[31:0], 32'hffff_fffc);
		chk32(msi_addr[63:32], 32'hffff_ffff);
		chk32({16'h0, msi_data}, 32'h0000_ffff);
		u_host.xfer(1'b1, 32'hf8, 32'h0, 3'h0, q);
		rd(32'hf8, 32'hffff_ffff);
		chk1(hresp, 1'b0);
		$display("test register access done");
	endtask
	task automatic t_intx();
		intx_pin <= 1'b1;
		hold(5);
		chk1(intx_out, 1'b1);
		intx_pin <= 1'b0;
		hold(5);
		wr(32'hf0, 32'h0001_0000);
		chk1(msi_enable, 1'b1);
		intx_pin <= 1'b1;
		m = 1'b0;
		repeat (6) begin
			@(posedge hclk);
			m = m | report.msi_write;
		end
		chk1(m, 1'b1);
		chk1(intx_out, 1'b0);
		intx_pin <= 1'b0;
		wr(32'hf0, 32'h0);
		$display("test interrupt delivery done");
	endtask
	task automatic t_err();
		wr(32'h108, 32'h0000_4000);
		wr(32'h10c, 32'h0006_2011);
		pulse(0);
		chk32({f, n}, 2'b10);
		pulse(12);
		chk32({f, n}, 2'b01);
		pulse(14);
		chk32({f, n}, 2'b00);
		pulse(1);
		rd(32'h104, 32'h0000_5001);
		rd(32'h140, 32'h7);
		chk1(irq, 1'b1);
		wr(32'h144, 32'h7);
		hold(2);
		chk1(irq, 1'b0);
		wr(32'h144, 32'h0);
		wr(32'h140, 32'h7);
		hold(2);
		chk1(irq, 1'b0);
		wr(32'h104, 32'h1);
		rd(32'h104, 32'h0000_5000);
		$display("test error reporting done");
	endtask
	task automatic t_sticky();
		wr(32'hf4, 32'h1234_5678);
		wr(32'h10c, 32'h1);
		hot_rst <= 1'b1;
		@(posedge hclk);
		hot_rst <= 1'b0;
		@(posedge hclk);
		rd(32'hf4, 32'h0);
		rd(32'h104, 32'h0000_5000);
		rd(32'h108, 32'h0000_4000);
		rd(32'h10c, 32'h1);
		do_reset();
		rd(32'h104, 32'h0);
		rd(32'h108, 32'h0);
		rd(32'h10c, 32'h0006_2011);
		$display("test sticky reset done");
	endtask
	initial begin
		do_reset();
		t_reset();
		t_rw();
		t_intx();
		t_err();
		t_sticky();
		tally_and_finish();
	end
endmodule
`default_nettype wire
